// ===== pkg/ivp_regs.svh
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// Geometry of the source set and of the vector field
`define IVP_NSRC        16
`define IVP_IDX_W       4
`define IVP_VEC_W       7
`define IVP_PRIO_W      5
`define IVP_NUM_W       5

// Source index, equal to priority minus one
`define IVP_IDX_RESET   4'h0
`define IVP_IDX_NMI     4'h1
`define IVP_IDX_LAST    4'hf

// Priority numbers the checks refer to
`define IVP_PRIO_RESET  5'h01
`define IVP_PRIO_NMI    5'h02
`define IVP_PRIO_EXT0   5'h03
`define IVP_PRIO_EXT3   5'h0b
`define IVP_PRIO_SP0RX  5'h07
`define IVP_PRIO_SP1TX  5'h0e
`define IVP_PRIO_XFER4  5'h0f
`define IVP_PRIO_XFER5  5'h10

// Vector slots, relative to the vector base, one per priority
`define IVP_VEC_P01     7'h00
`define IVP_VEC_P02     7'h04
`define IVP_VEC_P03     7'h40
`define IVP_VEC_P04     7'h44
`define IVP_VEC_P05     7'h48
`define IVP_VEC_P06     7'h4c
`define IVP_VEC_P07     7'h50
`define IVP_VEC_P08     7'h54
`define IVP_VEC_P09     7'h58
`define IVP_VEC_P10     7'h5c
`define IVP_VEC_P11     7'h60
`define IVP_VEC_P12     7'h64
`define IVP_VEC_P13     7'h68
`define IVP_VEC_P14     7'h6c
`define IVP_VEC_P15     7'h70
`define IVP_VEC_P16     7'h74

// Software-only traps without hardware priority
`define IVP_SW_FIRST    5'h11
`define IVP_SW_LAST     5'h1e
`define IVP_SW_BASE     7'h08
`define IVP_SLOT_STEP   7'h04
`define IVP_RSV_BASE    7'h78
`define IVP_VEC_SW_LAST 7'h3c

// Sources that the mask cannot hold off, and the all-zero flag, slot and priority values
`define IVP_UNMASKABLE  16'h0003
`define IVP_ZERO_FLAGS  16'h0000
`define IVP_ZERO_VEC    7'h00
`define IVP_ZERO_PRIO   5'h00

// Idle levels of the active-low lines, and priority-to-index offset
`define IVP_PINS_IDLE   4'hf
`define IVP_PIN_IDLE    1'b1
`define IVP_IDX_OFS     4'h1

`endif

// ===== pkg/ivp_pkg.sv
`include "ivp_regs.svh"

package ivp_pkg;

	// Selected hardware request as handed to the sequencer
	typedef struct packed {
		logic                    valid;
		logic [`IVP_PRIO_W-1:0]  prio;
		logic [`IVP_VEC_W-1:0]   vec;
	} ivp_sel_s;

	// Software-only trap slot
	typedef struct packed {
		logic                    valid;
		logic [`IVP_VEC_W-1:0]   vec;
	} ivp_swv_s;

endpackage : ivp_pkg

// ===== rtl/ivp_top.sv
`timescale 1ns/1ps
`include "ivp_regs.svh"

module ivp_top
	import ivp_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   reset_pin_n_in,
	input  wire logic                   sw_reset_trap_in,
	input  wire logic                   nmi_pin_n_in,
	input  wire logic                   sw_trap_nonmask_in,
	input  wire logic                   ext_req0_n_in,
	input  wire logic                   ext_req1_n_in,
	input  wire logic                   ext_req2_n_in,
	input  wire logic                   ext_req3_n_in,
	input  wire logic                   timer_event_in,
	input  wire logic                   sport0_rx_event_in,
	input  wire logic                   sport0_tx_event_in,
	input  wire logic                   sport2_rx_event_in,
	input  wire logic                   sport2_tx_event_in,
	input  wire logic                   sport1_rx_event_in,
	input  wire logic                   sport1_tx_event_in,
	input  wire logic                   host_port_event_in,
	input  wire logic                   xfer_chan4_event_in,
	input  wire logic                   xfer_chan5_event_in,
	input  wire logic [`IVP_NSRC-1:0]   irq_mask_reg_in,
	input  wire logic                   core_ack_in,
	input  wire logic                   sw_trap_valid_in,
	input  wire logic [`IVP_NUM_W-1:0]  sw_trap_num_in,
	output logic                        irq_req_out,
	output logic [`IVP_PRIO_W-1:0]      irq_prio_out,
	output logic [`IVP_VEC_W-1:0]       irq_vec_out,
	output logic [`IVP_NSRC-1:0]        irq_flag_reg_out,
	output logic                        sw_vec_valid_out,
	output logic [`IVP_VEC_W-1:0]       sw_vec_out
);

	logic [`IVP_NSRC-1:0]   irq_flag_reg_ff;
	logic [`IVP_NSRC-1:0]   nxt_irq_flag_reg;
	logic [`IVP_NSRC-1:0]   set_vec;
	logic [`IVP_NSRC-1:0]   clr_vec;
	logic [`IVP_NSRC-1:0]   enable_vec;
	logic [`IVP_NSRC-1:0]   live_vec;
	logic [3:0]             pin_prev_ff;
	logic                   nmi_prev_ff;
	logic [3:0]             pin_fall;
	logic                   nmi_fall;
	ivp_sel_s               sel_ff;
	ivp_sel_s               nxt_sel;
	ivp_swv_s               swv_ff;
	ivp_swv_s               nxt_swv;
	logic [`IVP_IDX_W-1:0]  served_idx;

	// Slot lookup by source index; the table holds the sixteen hardware-priority slots, not the software trap slots
	function automatic logic [`IVP_VEC_W-1:0] slot_of(
		input logic [`IVP_IDX_W-1:0] idx
	);
		case (idx)
			4'h0:    slot_of = `IVP_VEC_P01;
			4'h1:    slot_of = `IVP_VEC_P02;
			4'h2:    slot_of = `IVP_VEC_P03;
			4'h3:    slot_of = `IVP_VEC_P04;
			4'h4:    slot_of = `IVP_VEC_P05;
			4'h5:    slot_of = `IVP_VEC_P06;
			4'h6:    slot_of = `IVP_VEC_P07;
			4'h7:    slot_of = `IVP_VEC_P08;
			4'h8:    slot_of = `IVP_VEC_P09;
			4'h9:    slot_of = `IVP_VEC_P10;
			4'ha:    slot_of = `IVP_VEC_P11;
			4'hb:    slot_of = `IVP_VEC_P12;
			4'hc:    slot_of = `IVP_VEC_P13;
			4'hd:    slot_of = `IVP_VEC_P14;
			4'he:    slot_of = `IVP_VEC_P15;
			4'hf:    slot_of = `IVP_VEC_P16;
			default: slot_of = `IVP_VEC_P01;
		endcase
	endfunction : slot_of

	////////////////////////////////////////////////////////////////////////
	// Event capture

	// Previous pin levels, pins idle high
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_prev_ff <= `IVP_PINS_IDLE;
			nmi_prev_ff <= `IVP_PIN_IDLE;
		end else begin
			pin_prev_ff <= {ext_req3_n_in, ext_req2_n_in,
				ext_req1_n_in, ext_req0_n_in};
			nmi_prev_ff <= nmi_pin_n_in;
		end
	end

	// Falling edges; a held-low line requests once, not every cycle
	assign pin_fall = pin_prev_ff & ~{ext_req3_n_in, ext_req2_n_in,
		ext_req1_n_in, ext_req0_n_in};
	assign nmi_fall = nmi_prev_ff & ~nmi_pin_n_in;

	// Source bit i stands for priority i+1
	assign set_vec = {
		xfer_chan5_event_in,
		xfer_chan4_event_in,
		sport1_tx_event_in,
		sport1_rx_event_in,
		host_port_event_in,
		pin_fall[3],
		sport2_tx_event_in,
		sport2_rx_event_in,
		sport0_tx_event_in,
		sport0_rx_event_in,
		timer_event_in,
		pin_fall[2],
		pin_fall[1],
		pin_fall[0],
		nmi_fall | sw_trap_nonmask_in,
		~reset_pin_n_in | sw_reset_trap_in
	};

	////////////////////////////////////////////////////////////////////////
	// Pending flags

	// Ack clears only the source that was on offer
	assign served_idx = sel_ff.prio[`IVP_IDX_W-1:0] - `IVP_IDX_OFS;
	always_comb begin
		clr_vec = `IVP_ZERO_FLAGS;
		if (core_ack_in && sel_ff.valid) begin
			clr_vec[served_idx] = 1'b1;
		end
	end

	// Set beats clear so an event landing on its own ack is kept
	assign nxt_irq_flag_reg = (irq_flag_reg_ff & ~clr_vec) | set_vec;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_flag_reg_ff <= `IVP_ZERO_FLAGS;
		end else begin
			irq_flag_reg_ff <= nxt_irq_flag_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority selection

	// Reset and nonmaskable request ignore the mask
	assign enable_vec = irq_mask_reg_in | `IVP_UNMASKABLE;
	assign live_vec   = nxt_irq_flag_reg & enable_vec;

	// Downward scan so the last hit is the smallest priority number
	always_comb begin
		nxt_sel = '0;
		for (int i = `IVP_NSRC - 1; i >= 0; i--) begin
			if (live_vec[i]) begin
				nxt_sel.valid = 1'b1;
				nxt_sel.prio  = `IVP_PRIO_W'(i + 1);
				nxt_sel.vec   = slot_of(`IVP_IDX_W'(i));
			end
		end
	end

	// Offer is taken from next flags, so an ack never shows a stale slot
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sel_ff <= '0;
		end else begin
			sel_ff <= nxt_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-only traps

	// Traps outside the software-only range are dropped here
	always_comb begin
		nxt_swv = '0;
		if (sw_trap_valid_in && sw_trap_num_in >= `IVP_SW_FIRST &&
			sw_trap_num_in <= `IVP_SW_LAST) begin
			nxt_swv.valid = 1'b1;
			nxt_swv.vec   = `IVP_SW_BASE + `IVP_SLOT_STEP *
				`IVP_VEC_W'(sw_trap_num_in - `IVP_SW_FIRST);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			swv_ff <= '0;
		end else begin
			swv_ff <= nxt_swv;
		end
	end

	assign irq_req_out      = sel_ff.valid;
	assign irq_prio_out     = sel_ff.prio;
	assign irq_vec_out      = sel_ff.vec;
	assign irq_flag_reg_out = irq_flag_reg_ff;
	assign sw_vec_valid_out = swv_ff.valid;
	assign sw_vec_out       = swv_ff.vec;

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_no_reserved_slot: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(sel_ff.valid || swv_ff.valid) |->
			(sel_ff.vec < `IVP_RSV_BASE && swv_ff.vec < `IVP_RSV_BASE))
		else $error("reserved slot offered");

	chk_sw_trap_slot: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(sw_trap_valid_in && sw_trap_num_in == `IVP_SW_LAST) |=>
			(swv_ff.valid && swv_ff.vec == `IVP_VEC_SW_LAST))
		else $error("last software trap slot wrong");

	chk_reset_wins_slot: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(!reset_pin_n_in && $past(rst_n_in)) |=>
			(sel_ff.valid && sel_ff.prio == `IVP_PRIO_RESET &&
			sel_ff.vec == `IVP_VEC_P01))
		else $error("reset not offered at top priority");

	chk_nmi_slot_map: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(sel_ff.valid && sel_ff.prio == `IVP_PRIO_NMI) |->
			sel_ff.vec == `IVP_VEC_P02)
		else $error("nonmaskable slot wrong");

	chk_ext_line_slot: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sel_ff.valid |->
			((sel_ff.prio == `IVP_PRIO_EXT0) == (sel_ff.vec == `IVP_VEC_P03)) &&
			((sel_ff.prio == `IVP_PRIO_EXT3) == (sel_ff.vec == `IVP_VEC_P11)))
		else $error("external line slot wrong");

	chk_sport_slot_map: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sel_ff.valid |->
			((sel_ff.prio == `IVP_PRIO_SP0RX) == (sel_ff.vec == `IVP_VEC_P07)) &&
			((sel_ff.prio == `IVP_PRIO_SP1TX) == (sel_ff.vec == `IVP_VEC_P14)))
		else $error("serial port slot wrong");

	chk_xfer_slot_map: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(sel_ff.valid && sel_ff.prio >= `IVP_PRIO_XFER4) |->
			(sel_ff.vec == (sel_ff.prio == `IVP_PRIO_XFER5 ?
			`IVP_VEC_P16 : `IVP_VEC_P15)))
		else $error("transfer channel slot wrong");

	chk_lowest_first: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sel_ff.valid |->
			((irq_flag_reg_ff & ($past(irq_mask_reg_in) | `IVP_UNMASKABLE) &
			((`IVP_NSRC'(1) << served_idx) - `IVP_NSRC'(1))) ==
			`IVP_ZERO_FLAGS))
		else $error("a smaller priority number was passed over");

	chk_others_kept: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(core_ack_in && sel_ff.valid &&
			((irq_flag_reg_ff & ~clr_vec) != `IVP_ZERO_FLAGS)) |=>
			((irq_flag_reg_ff & ~$past(clr_vec)) != `IVP_ZERO_FLAGS))
		else $error("pending request lost on ack");

endmodule : ivp_top

// ===== verif/ivp_core_model.sv
`timescale 1ns/1ps
`include "ivp_regs.svh"

// Core sequencer stand-in: takes the standing offer on each cycle of the ack window
module ivp_core_model
	import ivp_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   ack_en_in,
	input  wire logic                   irq_req_in,
	input  wire logic [`IVP_PRIO_W-1:0] irq_prio_in,
	input  wire logic [`IVP_VEC_W-1:0]  irq_vec_in,
	output logic                        core_ack_out,
	output logic [`IVP_PRIO_W-1:0]      taken_prio_out,
	output logic [`IVP_VEC_W-1:0]       taken_vec_out
);

////////////////////////////////////////////////////////////////////////
// Ack only while an offer stands, like a real fetch sequencer
// Enable is low from time zero, so the first falling edge clears the ack
always @(negedge clk_in) begin
	core_ack_out <= ack_en_in & irq_req_in;
end

// Keep what was accepted at the taking edge
always @(posedge clk_in) begin
	if (core_ack_out && irq_req_in) begin
		taken_prio_out <= irq_prio_in;
		taken_vec_out  <= irq_vec_in;
	end
end

endmodule : ivp_core_model

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "ivp_regs.svh"

`define TB_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
	err_total++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
	import ivp_pkg::*;

////////////////////////////////////////////////////////////////////////
// Bench drives plain sources in act, pins are inverted at the instance
logic                  clk_in, rst_n_in, ack_en, core_ack_in;
logic                  sw_reset_trap_in, sw_trap_nonmask_in;
logic                  sw_trap_valid_in, irq_req_out, sw_vec_valid_out;
logic [`IVP_NUM_W-1:0] sw_trap_num_in;
logic [15:0]           act, irq_mask_reg_in, irq_flag_reg_out;
logic [4:0]            irq_prio_out, taken_prio;
logic [6:0]            irq_vec_out, sw_vec_out, taken_vec;
int                    err_total, cmp_count, cyc;
logic [6:0] exp_vec [16] = '{7'h00, 7'h04, 7'h40, 7'h44, 7'h48, 7'h4c,
	7'h50, 7'h54, 7'h58, 7'h5c, 7'h60, 7'h64, 7'h68, 7'h6c, 7'h70, 7'h74};

ivp_top DUT (.clk_in, .rst_n_in, .reset_pin_n_in(~act[0]),
	.sw_reset_trap_in, .nmi_pin_n_in(~act[1]), .sw_trap_nonmask_in,
	.ext_req0_n_in(~act[2]), .ext_req1_n_in(~act[3]),
	.ext_req2_n_in(~act[4]), .ext_req3_n_in(~act[10]),
	.timer_event_in(act[5]), .sport0_rx_event_in(act[6]),
	.sport0_tx_event_in(act[7]), .sport2_rx_event_in(act[8]),
	.sport2_tx_event_in(act[9]), .sport1_rx_event_in(act[12]),
	.sport1_tx_event_in(act[13]), .host_port_event_in(act[11]),
	.xfer_chan4_event_in(act[14]), .xfer_chan5_event_in(act[15]),
	.irq_mask_reg_in, .core_ack_in, .sw_trap_valid_in, .sw_trap_num_in,
	.irq_req_out, .irq_prio_out, .irq_vec_out, .irq_flag_reg_out,
	.sw_vec_valid_out, .sw_vec_out);

ivp_core_model core (.clk_in, .ack_en_in(ack_en), .irq_req_in(irq_req_out),
	.irq_prio_in(irq_prio_out), .irq_vec_in(irq_vec_out),
	.core_ack_out(core_ack_in), .taken_prio_out(taken_prio),
	.taken_vec_out(taken_vec));

////////////////////////////////////////////////////////////////////////
// One-cycle source pulse; outputs are read after the capturing edge
task automatic pulse(input logic [15:0] m);
	@(negedge clk_in) act <= m;
	@(negedge clk_in) act <= 16'h0000;
endtask : pulse

// One-cycle ack window, so a second pending source is not taken too
task automatic take;
	@(negedge clk_in) ack_en <= 1'b1;
	@(negedge clk_in) ack_en <= 1'b0;
	@(negedge clk_in);
endtask : take

// Each source alone: slot and priority, flag cleared by its ack
task automatic t_map;
	for (int i = 0; i < 16; i++) begin
		pulse(16'h0001 << i);
		`TB_CHK(irq_prio_out, 5'(i + 1))
		`TB_CHK(irq_vec_out, exp_vec[i])
		`TB_CHK(irq_flag_reg_out, 16'h0001 << i)
		take();
		`TB_CHK(taken_vec, exp_vec[i])
		`TB_CHK(irq_flag_reg_out, 16'h0000)
	end
	$display("test map done");
endtask : t_map

// All sources at once are served strictly by rising priority number
task automatic t_prio;
	pulse(16'hffff);
	for (int k = 0; k < 16; k++) begin
		`TB_CHK(irq_prio_out, 5'(k + 1))
		take();
		`TB_CHK(taken_prio, 5'(k + 1))
		`TB_CHK(irq_flag_reg_out, 16'hffff << (k + 1))
	end
	$display("test priority done");
endtask : t_prio

// Masked sources wait; the nonmaskable one passes a closed mask
task automatic t_mask;
	@(negedge clk_in) irq_mask_reg_in <= 16'h0000;
	pulse(16'h0026);
	`TB_CHK(irq_vec_out, 7'h04)
	take();
	`TB_CHK(irq_req_out, 1'b0)
	`TB_CHK(irq_flag_reg_out, 16'h0024)
	irq_mask_reg_in <= 16'h0020;
	@(negedge clk_in) `TB_CHK(irq_vec_out, 7'h4c)
	irq_mask_reg_in <= 16'hffff;
	@(negedge clk_in) `TB_CHK(irq_prio_out, 5'h03)
	take();
	take();
	`TB_CHK(irq_flag_reg_out, 16'h0000)
	$display("test mask done");
endtask : t_mask

// Software reset and traps; numbers outside the soft range are dropped
task automatic t_sw;
	@(negedge clk_in) sw_reset_trap_in <= 1'b1;
	@(negedge clk_in) sw_reset_trap_in <= 1'b0;
	`TB_CHK({irq_prio_out, irq_vec_out}, {5'h01, 7'h00})
	take();
	sw_trap_nonmask_in <= 1'b1;
	@(negedge clk_in) sw_trap_nonmask_in <= 1'b0;
	`TB_CHK({irq_prio_out, irq_vec_out}, {5'h02, 7'h04})
	take();
	for (int n = 16; n < 32; n++) begin
		sw_trap_valid_in <= 1'b1;
		sw_trap_num_in   <= 5'(n);
		@(negedge clk_in) sw_trap_valid_in <= 1'b0;
		`TB_CHK(sw_vec_valid_out, 1'(n >= 17 && n <= 30))
		`TB_CHK(sw_vec_out, (n >= 17 && n <= 30) ? 7'(4 * n - 60) : 7'h00)
		@(negedge clk_in) `TB_CHK(sw_vec_valid_out, 1'b0)
	end
	$display("test software done");
endtask : t_sw

// Mid-run reset drops pending work; a line held low across release counts
task automatic t_rst;
	pulse(16'h0020);
	`TB_CHK(irq_flag_reg_out, 16'h0020)
	rst_n_in <= 1'b0;
	@(negedge clk_in) act <= 16'h0004;
	@(negedge clk_in) `TB_CHK({irq_req_out, irq_flag_reg_out}, 17'h00000)
	rst_n_in <= 1'b1;
	@(negedge clk_in) act <= 16'h0000;
	`TB_CHK(irq_flag_reg_out, 16'h0004)
	`TB_CHK({irq_prio_out, irq_vec_out}, {5'h03, 7'h40})
	take();
	`TB_CHK(irq_flag_reg_out, 16'h0000)
	$display("test reset done");
endtask : t_rst

// Verdict and end of run
task automatic finish_test;
	$display("compares %0d mismatches %0d", cmp_count, err_total);
	if (err_total == 0 && cmp_count > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask : finish_test

////////////////////////////////////////////////////////////////////////
initial begin
	clk_in = 1'b0;
	forever #2.5 clk_in = ~clk_in;
end

// Cut a hang short well beyond the few hundred cycles the tests need
always @(posedge clk_in) begin
	cyc++;
	if (cyc == 3000) begin
		err_total++;
		finish_test();
	end
end

initial begin
	rst_n_in = 1'b0;
	ack_en = 1'b0;
	act = 16'h0000;
	irq_mask_reg_in = 16'hffff;
	sw_reset_trap_in = 1'b0;
	sw_trap_nonmask_in = 1'b0;
	sw_trap_valid_in = 1'b0;
	sw_trap_num_in = 5'h00;
	repeat (20) @(negedge clk_in);
	`TB_CHK({irq_req_out, irq_flag_reg_out, sw_vec_valid_out}, 18'h00000)
	rst_n_in <= 1'b1;
	t_map();
	t_prio();
	t_mask();
	t_sw();
	t_rst();
	finish_test();
end

endmodule : tb
